// *** src/isbx_exec.sv ***
// Execution logic for decrement/increment-and-skip, jump, literal-OR, increment.
// Assumes the core presents one instruction per cycle with insn_valid and
// supplies the addressed file register contents combinationally.
`timescale 1ns/10ps
`default_nettype none
module isbx_exec (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Instruction in
   input wire logic insn_valid,
   input wire logic [isbx_pkg::ISBX_INSN_W-1:0] insn,
   // File register side
   input wire logic [isbx_pkg::ISBX_DATA_W-1:0] file_rdata,
   input wire logic [isbx_pkg::ISBX_DATA_W-1:0] program_counter_high_latch,
   output logic [isbx_pkg::ISBX_FADDR_W-1:0] file_addr,
   output logic [isbx_pkg::ISBX_DATA_W-1:0] file_wdata,
   output logic file_we,
   // Core state
   output logic [isbx_pkg::ISBX_DATA_W-1:0] acc,
   output logic [isbx_pkg::ISBX_DATA_W-1:0] status,
   output logic [isbx_pkg::ISBX_PC_W-1:0] pc,
   output logic nop_cycle,
   output logic jump_taken
);
   import isbx_pkg::*;

   typedef struct packed {
      logic [ISBX_DATA_W-1:0] acc;
      logic [ISBX_DATA_W-1:0] status;
      logic [ISBX_PC_W-1:0] pc;
      logic [ISBX_FADDR_W-1:0] faddr;
      logic [ISBX_DATA_W-1:0] fwdata;
      logic fwe;
      logic flush;
      logic jump;
   } isbx_state_s;

   isbx_state_s st_q, st_d;
   isbx_op_e op;
   logic [ISBX_DATA_W-1:0] alu_res;
   logic alu_zero;
   logic dest_file;
   logic exec;

   // ****************************************
   // Decode
   // ****************************************
   function automatic isbx_op_e isbx_decode(input logic [ISBX_INSN_W-1:0] w);
      isbx_op_e r;
      r = ISBX_EX_NONE;
      if (w[13:11] == ISBX_OP_JUMP) begin
         r = ISBX_EX_JUMP;
      end else if (w[13:8] == ISBX_OP_DECSKIP) begin
         r = ISBX_EX_DECSKIP;
      end else if (w[13:8] == ISBX_OP_INCSKIP) begin
         r = ISBX_EX_INCSKIP;
      end else if (w[13:8] == ISBX_OP_INC) begin
         r = ISBX_EX_INC;
      end else if (w[13:8] == ISBX_OP_ORLIT) begin
         r = ISBX_EX_ORLIT;
      end
      return r;
   endfunction

   // Instruction in a flush slot executes as a NOP
   assign exec = insn_valid && !st_q.flush;
   assign op = exec ? isbx_decode(insn) : ISBX_EX_NONE;
   assign dest_file = insn[ISBX_DEST_BIT];

   isbx_alu u_alu (
      .op(op),
      .file_val(file_rdata),
      .acc_val(st_q.acc),
      .literal(insn[7:0]),
      .result(alu_res),
      .result_zero(alu_zero)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      st_d = st_q;
      st_d.fwe = 1'b0;
      st_d.jump = 1'b0;
      st_d.faddr = insn[ISBX_FADDR_W-1:0];
      st_d.fwdata = alu_res;
      if (insn_valid) begin
         st_d.flush = 1'b0;
         st_d.pc = st_q.pc + 13'h0001;
      end
      unique case (op)
         ISBX_EX_DECSKIP,
         ISBX_EX_INCSKIP: begin
            if (dest_file) begin
               st_d.fwe = 1'b1;
            end else begin
               st_d.acc = alu_res;
            end
            st_d.flush = alu_zero;
         end
         ISBX_EX_INC: begin
            if (dest_file) begin
               st_d.fwe = 1'b1;
            end else begin
               st_d.acc = alu_res;
            end
            st_d.status[ISBX_STATUS_Z] = alu_zero;
         end
         ISBX_EX_ORLIT: begin
            st_d.acc = alu_res;
            st_d.status[ISBX_STATUS_Z] = alu_zero;
         end
         ISBX_EX_JUMP: begin
            st_d.pc = {program_counter_high_latch[ISBX_LATCH_HI:ISBX_LATCH_LO],
                       insn[10:0]};
            st_d.flush = 1'b1;
            st_d.jump = 1'b1;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q <= '{acc: ISBX_ACC_RST, status: ISBX_STATUS_RST, pc: ISBX_PC_RST,
                   faddr: '0, fwdata: '0, fwe: 1'b0, flush: 1'b0, jump: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign acc = st_q.acc;
   assign status = st_q.status;
   assign pc = st_q.pc;
   assign file_addr = st_q.faddr;
   assign file_wdata = st_q.fwdata;
   assign file_we = st_q.fwe;
   assign nop_cycle = st_q.flush;
   assign jump_taken = st_q.jump;

   // ****************************************
   // Checks
   // ****************************************
   sequence skip_zero_s;
      (op == ISBX_EX_DECSKIP || op == ISBX_EX_INCSKIP) && alu_zero;
   endsequence

   sequence skip_live_s;
      (op == ISBX_EX_DECSKIP || op == ISBX_EX_INCSKIP) && !alu_zero;
   endsequence

   sequence to_file_s;
      (op == ISBX_EX_DECSKIP || op == ISBX_EX_INCSKIP || op == ISBX_EX_INC) && dest_file;
   endsequence

   sequence slot_dropped_s;
      insn_valid && nop_cycle;
   endsequence

   sequence jump_then_slot_s;
      op == ISBX_EX_JUMP ##1 insn_valid;
   endsequence

   dec_result_a: assert property (@(posedge core_clk) disable iff (rst)
      op == ISBX_EX_DECSKIP && dest_file |=>
         file_we && file_wdata == $past(file_rdata) - 8'h01)
      else $error("decrement result wrong");
   dec_acc_a: assert property (@(posedge core_clk) disable iff (rst)
      op == ISBX_EX_DECSKIP && !dest_file |=>
         acc == $past(file_rdata) - 8'h01 && !file_we)
      else $error("decrement to accumulator wrong");
   file_route_a: assert property (@(posedge core_clk) disable iff (rst)
      to_file_s |=> file_we && file_addr == $past(insn[ISBX_FADDR_W-1:0]) && $stable(acc))
      else $error("file write routing wrong");
   skip_nop_a: assert property (@(posedge core_clk) disable iff (rst)
      skip_zero_s |=> nop_cycle)
      else $error("skip did not insert nop");
   noskip_a: assert property (@(posedge core_clk) disable iff (rst)
      skip_live_s |=> !nop_cycle)
      else $error("skip on nonzero");
   slot_drop_a: assert property (@(posedge core_clk) disable iff (rst)
      slot_dropped_s |=>
         !file_we && !jump_taken && !nop_cycle && $stable(acc) && $stable(status))
      else $error("discarded slot had an effect");
   inc_acc_a: assert property (@(posedge core_clk) disable iff (rst)
      op == ISBX_EX_INCSKIP && !dest_file |=>
         acc == $past(file_rdata) + 8'h01 && !file_we)
      else $error("increment to accumulator wrong");
   inc_file_a: assert property (@(posedge core_clk) disable iff (rst)
      (op == ISBX_EX_INCSKIP || op == ISBX_EX_INC) && dest_file |=>
         file_wdata == $past(file_rdata) + 8'h01)
      else $error("increment to file wrong");
   inc_plain_acc_a: assert property (@(posedge core_clk) disable iff (rst)
      op == ISBX_EX_INC && !dest_file |=>
         acc == $past(file_rdata) + 8'h01 && !file_we)
      else $error("plain increment to accumulator wrong");
   jump_pc_a: assert property (@(posedge core_clk) disable iff (rst)
      op == ISBX_EX_JUMP |=> pc[10:0] == $past(insn[10:0]) && jump_taken)
      else $error("jump low bits wrong");
   jump_hi_a: assert property (@(posedge core_clk) disable iff (rst)
      op == ISBX_EX_JUMP |=>
         pc[12:11] == $past(program_counter_high_latch[ISBX_LATCH_HI:ISBX_LATCH_LO]))
      else $error("jump high bits wrong");
   jump_flags_a: assert property (@(posedge core_clk) disable iff (rst)
      op == ISBX_EX_JUMP |=> nop_cycle && $stable(status))
      else $error("jump cycle count or flags wrong");
   jump_slot_a: assert property (@(posedge core_clk) disable iff (rst)
      jump_then_slot_s |=>
         !file_we && !jump_taken && pc == $past(pc) + 13'h0001 && $stable(acc))
      else $error("slot after jump not discarded");
   skip_flags_a: assert property (@(posedge core_clk) disable iff (rst)
      op == ISBX_EX_DECSKIP || op == ISBX_EX_INCSKIP |=> $stable(status))
      else $error("skip changed status");
   or_zero_a: assert property (@(posedge core_clk) disable iff (rst)
      op == ISBX_EX_ORLIT |=> acc == ($past(acc) | $past(insn[7:0])) && !file_we
         && status[ISBX_STATUS_Z] == (acc == 8'h00))
      else $error("literal or wrong");
   inc_zero_a: assert property (@(posedge core_clk) disable iff (rst)
      op == ISBX_EX_INC |=> status[ISBX_STATUS_Z] == ($past(file_rdata) == 8'hFF))
      else $error("increment zero flag wrong");

endmodule
`default_nettype wire

// *** src/isbx_pkg.sv ***
// Package for the five-instruction execution block of a small 8-bit core.
// Assumes the core supplies an undecoded 14-bit instruction word and file data.
//
// Overview of operation
// - Decrement-and-skip takes file minus one to acc (d=0) or file (d=1), flags kept.
// - A zero decrement result drops the fetched next instruction for a NOP cycle.
// - Increment-and-skip routes file plus one by the destination bit, flags kept.
// - An increment-and-skip result that wraps to zero replaces the next instruction by a NOP cycle.
// - The absolute jump loads its 11-bit operand into program counter bits 10 to 0.
// - On the absolute jump, program counter bits 12:11 come from high latch bits 4:3.
// - The absolute jump always branches, takes two cycles and leaves all flags alone.
// - Literal-OR stores accumulator OR 8-bit literal in the accumulator, updating zero.
// - Plain increment routes file plus one by the destination bit and updates zero.
// - The status register holds a zero bit that flag-affecting instructions update.
package isbx_pkg;

   // ****************************************
   // Widths and encodings
   // ****************************************
   localparam int ISBX_DATA_W = 8;
   localparam int ISBX_PC_W = 13;
   localparam int ISBX_FADDR_W = 7;
   localparam int ISBX_INSN_W = 14;
   localparam logic [5:0] ISBX_OP_DECSKIP = 6'h0B;
   localparam logic [5:0] ISBX_OP_INCSKIP = 6'h0F;
   localparam logic [5:0] ISBX_OP_INC = 6'h0A;
   localparam logic [5:0] ISBX_OP_ORLIT = 6'h38;
   localparam logic [2:0] ISBX_OP_JUMP = 3'h5;
   localparam int ISBX_DEST_BIT = 7;
   localparam int ISBX_LATCH_HI = 4;
   localparam int ISBX_LATCH_LO = 3;
   localparam int ISBX_STATUS_Z = 2;
   localparam logic [7:0] ISBX_ACC_RST = 8'h00;
   localparam logic [7:0] ISBX_STATUS_RST = 8'h18;
   localparam logic [12:0] ISBX_PC_RST = 13'h0000;

   typedef enum logic [2:0] {
      ISBX_EX_NONE, ISBX_EX_DECSKIP, ISBX_EX_INCSKIP, ISBX_EX_INC, ISBX_EX_ORLIT, ISBX_EX_JUMP
   } isbx_op_e;

endpackage

// *** src/isbx_alu.sv ***
// Arithmetic stage: result and zero detect for the four non-jump instructions.
// Assumes operands are stable within the cycle; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module isbx_alu (
   // Operation
   input wire isbx_pkg::isbx_op_e op,
   // Operands
   input wire logic [isbx_pkg::ISBX_DATA_W-1:0] file_val,
   input wire logic [isbx_pkg::ISBX_DATA_W-1:0] acc_val,
   input wire logic [isbx_pkg::ISBX_DATA_W-1:0] literal,
   // Result
   output logic [isbx_pkg::ISBX_DATA_W-1:0] result,
   output logic result_zero
);
   import isbx_pkg::*;

   always_comb begin
      unique case (op)
         ISBX_EX_DECSKIP: result = file_val - 8'h01;
         ISBX_EX_INCSKIP,
         ISBX_EX_INC: result = file_val + 8'h01;
         ISBX_EX_ORLIT: result = acc_val | literal;
         default: result = 8'h00;
      endcase
      result_zero = (result == 8'h00);
   end

endmodule
`default_nettype wire

// *** bench/test_incdec_skip_branch_or_exec.sv ***
// Self-checking bench for the five-instruction execution block.
// Assumes isbx_pkg and isbx_exec are compiled first; checks sit in the design.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
   $display("Error at %0t ns: got 0x%0h expected 0x%0h", $time, (got), (exp)); end end
module test_incdec_skip_branch_or_exec;
   import isbx_pkg::*;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic insn_valid = 1'b0;
   logic [13:0] insn = 14'h0000;
   logic [7:0] file_rdata = 8'h00;
   logic [7:0] latch = 8'h00;
   logic [6:0] file_addr;
   logic [7:0] file_wdata, acc, status;
   logic file_we, nop_cycle, jump_taken;
   logic [12:0] pc;
   logic [12:0] exp_pc = 13'h0000;
   int error_cnt = 0;
   int checks_done = 0;
   isbx_exec dut (.core_clk(core_clk), .rst(rst), .insn_valid(insn_valid), .insn(insn),
      .file_rdata(file_rdata), .program_counter_high_latch(latch), .file_addr(file_addr),
      .file_wdata(file_wdata), .file_we(file_we), .acc(acc), .status(status), .pc(pc),
      .nop_cycle(nop_cycle), .jump_taken(jump_taken));
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic issue(input logic [13:0] w, input logic [7:0] fd);
      insn = w;
      file_rdata = fd;
      insn_valid = 1'b1;
      @(negedge core_clk);
      exp_pc = exp_pc + 13'h0001;
   endtask
   task automatic discard_slot();
      logic [7:0] a;
      a = acc;
      issue({ISBX_OP_INC, 1'b0, 7'h11}, 8'h7F);
      `CHK(acc, a)
      `CHK({file_we, nop_cycle}, 2'h0)
      `CHK(pc, exp_pc)
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_dec_skip();
      logic [7:0] st;
      st = status;
      issue({ISBX_OP_DECSKIP, 1'b1, 7'h05}, 8'h01);
      `CHK({file_we, file_addr, file_wdata}, {1'b1, 7'h05, 8'h00})
      `CHK(status, st)
      `CHK(nop_cycle, 1'b1)
      discard_slot();
      issue({ISBX_OP_DECSKIP, 1'b0, 7'h7F}, 8'h10);
      `CHK({acc, file_we, nop_cycle}, {8'h0F, 2'h0})
      issue({ISBX_OP_DECSKIP, 1'b0, 7'h00}, 8'h00);
      `CHK({acc, nop_cycle, status}, {8'hFF, 1'b0, st})
   endtask
   task automatic t_inc_skip();
      logic [7:0] st;
      st = status;
      issue({ISBX_OP_INCSKIP, 1'b0, 7'h03}, 8'hFF);
      `CHK({acc, file_we, status}, {8'h00, 1'b0, st})
      `CHK(nop_cycle, 1'b1)
      discard_slot();
      issue({ISBX_OP_INCSKIP, 1'b1, 7'h7F}, 8'h7F);
      `CHK({file_we, file_addr, file_wdata, acc}, {1'b1, 7'h7F, 8'h80, 8'h00})
      `CHK({nop_cycle, status}, {1'b0, st})
   endtask
   task automatic t_jump();
      logic [7:0] lat[3] = '{8'h18, 8'h08, 8'hE7};
      logic [10:0] k[3] = '{11'h7FF, 11'h000, 11'h555};
      logic [7:0] st;
      for (int i = 0; i < 3; i++) begin
         st = status;
         latch = lat[i];
         issue({ISBX_OP_JUMP, k[i]}, 8'h00);
         exp_pc = {lat[i][4:3], k[i]};
         `CHK(pc[10:0], k[i])
         `CHK(pc[12:11], lat[i][4:3])
         `CHK({jump_taken, nop_cycle, status}, {2'h3, st})
         discard_slot();
         `CHK(jump_taken, 1'b0)
      end
   endtask
   task automatic t_or_zero();
      logic [7:0] st;
      st = status;
      issue({ISBX_OP_INC, 1'b0, 7'h09}, 8'hFF);
      `CHK({acc, status}, {8'h00, st | 8'h04})
      issue({ISBX_OP_ORLIT, 8'h00}, 8'h00);
      `CHK({acc, status[ISBX_STATUS_Z]}, {8'h00, 1'b1})
      issue({ISBX_OP_ORLIT, 8'hA5}, 8'h00);
      `CHK({acc, status}, {8'hA5, st & 8'hFB})
      issue({ISBX_OP_ORLIT, 8'h5A}, 8'h00);
      `CHK({acc, status[ISBX_STATUS_Z]}, {8'hFF, 1'b0})
   endtask
   task automatic t_inc();
      issue({ISBX_OP_INC, 1'b1, 7'h2A}, 8'h41);
      `CHK({file_we, file_addr, file_wdata, acc}, {1'b1, 7'h2A, 8'h42, 8'hFF})
      `CHK(status[ISBX_STATUS_Z], 1'b0)
      issue({ISBX_OP_INC, 1'b1, 7'h2B}, 8'hFF);
      `CHK({file_wdata, nop_cycle, status[ISBX_STATUS_Z]}, {8'h00, 2'h1})
      issue({ISBX_OP_DECSKIP, 1'b0, 7'h2B}, 8'h05);
      `CHK({acc, nop_cycle, status[ISBX_STATUS_Z]}, {8'h04, 2'h1})
   endtask
   task automatic t_unknown();
      logic [7:0] a, st;
      a = acc;
      st = status;
      issue({6'h07, 1'b1, 7'h10}, 8'hFF);
      `CHK({acc, status, file_we, nop_cycle, jump_taken}, {a, st, 3'h0})
      `CHK(pc, exp_pc)
   endtask
   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      repeat (12) @(negedge core_clk);
      rst = 1'b0;
      @(negedge core_clk);
      `CHK({acc, status, pc}, {ISBX_ACC_RST, ISBX_STATUS_RST, ISBX_PC_RST})
      `CHK({file_we, nop_cycle, jump_taken}, 3'h0)
      t_dec_skip();
      t_inc_skip();
      t_jump();
      t_or_zero();
      t_inc();
      t_unknown();
      final_report();
   end
   initial begin
      repeat (400) @(posedge core_clk);
      error_cnt++;
      final_report();
   end
endmodule
`default_nettype wire
